// file: bench/mul_asserts.sv
`timescale 1ns/1ps
module mul_asserts #(
    parameter int WIDTH = 8,
    parameter int FLAGS = 8
) (
    // clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             reset_in,
    // commands and data into the multiplier
    input  wire logic             mul_go_in,
    input  wire logic [WIDTH-1:0] file_operand_in,
    input  wire logic             working_register_we_in,
    input  wire logic [WIDTH-1:0] working_register_data_in,
    input  wire logic             prod_high_we_in,
    input  wire logic             prod_low_we_in,
    input  wire logic [WIDTH-1:0] prod_data_in,
    input  wire logic             flags_we_in,
    input  wire logic [FLAGS-1:0] flags_data_in,
    // state out of the multiplier
    input  wire logic [WIDTH-1:0] working_register_out,
    input  wire logic [WIDTH-1:0] product_high_byte_out,
    input  wire logic [WIDTH-1:0] product_low_byte_out,
    input  wire logic [FLAGS-1:0] alu_flag_register_out,
    input  wire logic             mul_done_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    AST_DONE: assert property (mul_go_in |=> mul_done_out)
        else $error("done missing after multiply");
    AST_IDLE: assert property (!mul_go_in |=> !mul_done_out)
        else $error("done without multiply");
    AST_PRODUCT: assert property (mul_go_in |=>
        {product_high_byte_out, product_low_byte_out}
        == $past(working_register_out) * $past(file_operand_in))
        else $error("wrong product");
    AST_FLAGS: assert property (mul_go_in && !flags_we_in
        |=> $stable(alu_flag_register_out)) else $error("flags moved");
    AST_WORKING_REGISTER: assert property (mul_go_in && !working_register_we_in
        |=> $stable(working_register_out)) else $error("operand moved");
    AST_HOLD: assert property (!(mul_go_in || prod_high_we_in
        || prod_low_we_in) |=> $stable(product_low_byte_out)
        && $stable(product_high_byte_out)) else $error("product moved");
    cover property (mul_go_in ##1 mul_go_in);
    cover property (mul_go_in && prod_high_we_in);
    cover property (mul_go_in && working_register_we_in);
endmodule

// file: bench/seq_fixup.sv
`timescale 1ns/1ps
module seq_fixup (
    // operands and unsigned high byte
    input  wire logic [7:0] a_in,
    input  wire logic [7:0] b_in,
    input  wire logic [7:0] hi_in,
    // signed high byte
    output logic      [7:0] sh_out
);
    // subtract each operand whose partner is negative
    assign sh_out = hi_in - (b_in[7] ? a_in : 8'h00)
                    - (a_in[7] ? b_in : 8'h00);
endmodule

// file: bench/test_unsigned_byte_multiplier.sv
`timescale 1ns/1ps
module test_unsigned_byte_multiplier;
    logic clk_sys_in = 0, reset_in = 1, go = 0, wwe = 0, hwe = 0, lwe = 0;
    logic fwe = 0, done;
    logic [7:0] fop = 0, wd = 0, pd = 0, fd = 8'h5a, w, hi, lo, fl, sh;
    int err_count = 0, checks = 0;
    logic [31:0] r16;
    // working operand, file operand, expected product
    logic [31:0] rows [4] = '{32'h0000_0000, 32'hffff_fe01, 32'h80ff_7f80,
                              32'h0d07_005b};
    always #4 clk_sys_in = ~clk_sys_in;
    unsigned_byte_multiplier dut_u (.clk_sys_in, .reset_in, .mul_go_in(go),
        .file_operand_in(fop), .working_register_we_in(wwe), .working_register_data_in(wd),
        .prod_high_we_in(hwe), .prod_low_we_in(lwe), .prod_data_in(pd),
        .flags_we_in(fwe), .flags_data_in(fd), .working_register_out(w),
        .product_high_byte_out(hi), .product_low_byte_out(lo),
        .alu_flag_register_out(fl), .mul_done_out(done));
    seq_fixup seq_u (.a_in(wd), .b_in(fop), .hi_in(hi), .sh_out(sh));
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic mul(logic [7:0] a, logic [7:0] b);
        @(negedge clk_sys_in) {wwe, wd} = {1'b1, a};
        @(negedge clk_sys_in) {wwe, go, fop} = {2'b01, b};
        @(negedge clk_sys_in) go = 0;
    endtask
    task automatic mul16(logic [15:0] a, logic [15:0] b,
                         output logic [31:0] r);
        r = '0;
        for (int k = 0; k < 4; k++) begin
            mul(a[8*(k/2) +: 8], b[8*(k%2) +: 8]);
            r = r + ({16'h0, hi, lo} << (8 * (k/2 + k%2)));
        end
    endtask
    task results;
        if (err_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #20000 err_count++;
        results;
    end
    initial begin
        repeat (5) @(negedge clk_sys_in);
        chk("reset", 16'h0, {hi, lo});
        {reset_in, fwe} = 2'b01;
        @(negedge clk_sys_in) fwe = 0;
        foreach (rows[i]) begin
            mul(rows[i][31:24], rows[i][23:16]);
            chk("product", rows[i][15:0], {hi, lo});
            chk("done", 16'h1, done);
            chk("flags", 16'h5a, fl);
            chk("working_register", rows[i][31:24], w);
        end
        @(negedge clk_sys_in);
        {go, hwe, lwe, wwe, fop, pd, wd} = {4'hf, 24'h031122};
        @(negedge clk_sys_in) {hwe, lwe, wwe} = 0;
        chk("over", 16'h0027, {hi, lo});
        @(negedge clk_sys_in) go = 0;
        chk("next", 16'h0066, {hi, lo});
        {hwe, pd} = 9'h177;
        @(negedge clk_sys_in) hwe = 0;
        repeat (2) @(negedge clk_sys_in);
        chk("hold", 16'h7766, {hi, lo});
        chk("done low", 16'h0, done);
        mul(8'hfe, 8'h03);
        chk("signed", 16'h00ff, sh);
        mul16(16'h1234, 16'h5678, r16);
        chk("wide hi", 16'h0626, r16[31:16]);
        chk("wide lo", 16'h0060, r16[15:0]);
        @(negedge clk_sys_in) reset_in = 1;
        @(negedge clk_sys_in) reset_in = 0;
        chk("reset2 prod", 16'h0, {hi, lo});
        chk("reset2 regs", 16'h0, {w, fl});
        results;
    end
endmodule
bind unsigned_byte_multiplier mul_asserts #(.WIDTH(WIDTH), .FLAGS(FLAGS))
    chk_u (.*);

// file: inc/byte_mul_pkg.sv
package byte_mul_pkg;
    localparam int          OPERAND_W    = 8;
    localparam int          PRODUCT_W    = 2 * OPERAND_W;
    localparam int          FLAG_W       = 8;
    localparam int          LOW_LSB      = 0;
    localparam int          HIGH_LSB     = OPERAND_W;
    localparam logic [7:0]  PROD_BYTE_RST = 8'h00;
    localparam logic [7:0]  WORKING_REGISTER_RST      = 8'h00;
    localparam logic [7:0]  FLAG_RST      = 8'h00;
endpackage

// file: src/byte_mul_array.sv
`timescale 1ns/1ps
module byte_mul_array
    import byte_mul_pkg::*;
#(
    parameter int WIDTH = OPERAND_W
) (
    // operands
    input  wire logic [WIDTH-1:0]   a_in,
    input  wire logic [WIDTH-1:0]   b_in,
    // product
    output logic      [2*WIDTH-1:0] p_out
);
    logic [2*WIDTH-1:0] partial [WIDTH+1];

    assign partial[0] = '0;

    // shift-and-add array of unsigned partial products
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_row
            logic [2*WIDTH-1:0] term;
            assign term = b_in[gi]
                        ? ({{WIDTH{1'b0}}, a_in} << gi)
                        : '0;
            assign partial[gi+1] = partial[gi] + term;
        end
    endgenerate

    assign p_out = partial[WIDTH];
endmodule

// file: src/unsigned_byte_multiplier.sv
`timescale 1ns/1ps
module unsigned_byte_multiplier
    import byte_mul_pkg::*;
#(
    parameter int WIDTH = OPERAND_W,
    parameter int FLAGS = FLAG_W
) (
    // clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             reset_in,
    // multiply command
    input  wire logic             mul_go_in,
    input  wire logic [WIDTH-1:0] file_operand_in,
    // working register write
    input  wire logic             working_register_we_in,
    input  wire logic [WIDTH-1:0] working_register_data_in,
    // direct product writes
    input  wire logic             prod_high_we_in,
    input  wire logic             prod_low_we_in,
    input  wire logic [WIDTH-1:0] prod_data_in,
    // alu flag updates from other instructions
    input  wire logic             flags_we_in,
    input  wire logic [FLAGS-1:0] flags_data_in,
    // state
    output logic      [WIDTH-1:0] working_register_out,
    output logic      [WIDTH-1:0] product_high_byte_out,
    output logic      [WIDTH-1:0] product_low_byte_out,
    output logic      [FLAGS-1:0] alu_flag_register_out,
    output logic                  mul_done_out
);
    // timing: a multiply is taken at the edge where its command is high,
    // with the working register as it stood before that edge
    // the product bytes and the completion pulse show right after it
    // the pulse stands one cycle, the bytes until the next write
    // flags and the working register never see the multiply

    // working register group
    logic [WIDTH-1:0]   working_register_ff;
    logic [WIDTH-1:0]   nxt_working_register;

    // product byte groups
    logic [WIDTH-1:0]   prod_hi_ff;
    logic [WIDTH-1:0]   nxt_prod_hi;
    logic [WIDTH-1:0]   prod_lo_ff;
    logic [WIDTH-1:0]   nxt_prod_lo;

    // alu flag group
    logic [FLAGS-1:0]   flags_ff;
    logic [FLAGS-1:0]   nxt_flags;

    // completion group
    logic               done_ff;
    logic               nxt_done;

    // full product and its byte lanes
    logic [2*WIDTH-1:0] product;
    logic [WIDTH-1:0]   product_hi;
    logic [WIDTH-1:0]   product_lo;

    // reset values at the register widths
    localparam logic [WIDTH-1:0] WORKING_REGISTER_INIT = WIDTH'(WORKING_REGISTER_RST);
    localparam logic [WIDTH-1:0] PROD_INIT = WIDTH'(PROD_BYTE_RST);
    localparam logic [FLAGS-1:0] FLAG_INIT = FLAGS'(FLAG_RST);

    // one byte lane of a double-width value
    // lsb names the lowest bit of the lane
    function automatic logic [WIDTH-1:0] lane_of(
        input logic [2*WIDTH-1:0] value,
        input int                 lsb
    );
        lane_of = value[lsb +: WIDTH];
    endfunction

    // next value of one product byte
    // a direct write replaces the held byte
    // a multiply in the same cycle beats the direct write
    // with neither, the byte holds its value
    function automatic logic [WIDTH-1:0] next_byte(
        input logic [WIDTH-1:0] held,
        input logic             write_en,
        input logic [WIDTH-1:0] write_data,
        input logic             mul_go,
        input logic [WIDTH-1:0] mul_byte
    );
        logic [WIDTH-1:0] result;
        // hold by default
        result = held;
        if (write_en) begin
            result = write_data;
        end
        if (mul_go) begin
            result = mul_byte;
        end
        next_byte = result;
    endfunction

    // the array is purely combinational, so a multiply ends in one cycle
    // it reads the registered working value: a working register write
    // in the same cycle as a multiply does not reach that product
    byte_mul_array #(
        .WIDTH (WIDTH)
    ) u_array (
        .a_in  (working_register_ff),
        .b_in  (file_operand_in),
        .p_out (product)
    );

    // split the product into its byte lanes
    assign product_hi = lane_of(product, HIGH_LSB);
    assign product_lo = lane_of(product, LOW_LSB);

    // working register: moves only on its own write
    // the multiply reads it and never writes it
    always_comb begin
        // hold by default
        nxt_working_register = working_register_ff;
        if (working_register_we_in) begin
            nxt_working_register = working_register_data_in;
        end
    end

    // register the working value
    // reset clears it with the other registers
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            working_register_ff <= WORKING_REGISTER_INIT;
        end else begin
            working_register_ff <= nxt_working_register;
        end
    end

    // product high byte: upper half of the product on a multiply
    // a direct write may replace it between multiplies
    always_comb begin
        nxt_prod_hi = next_byte(
            prod_hi_ff,
            prod_high_we_in,
            prod_data_in,
            mul_go_in,
            product_hi
        );
    end

    // register the high byte
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            prod_hi_ff <= PROD_INIT;
        end else begin
            prod_hi_ff <= nxt_prod_hi;
        end
    end

    // product low byte: lower half of the product on a multiply
    // a direct write may replace it between multiplies
    always_comb begin
        nxt_prod_lo = next_byte(
            prod_lo_ff,
            prod_low_we_in,
            prod_data_in,
            mul_go_in,
            product_lo
        );
    end

    // register the low byte
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            prod_lo_ff <= PROD_INIT;
        end else begin
            prod_lo_ff <= nxt_prod_lo;
        end
    end

    // alu flags: only a flag write from another instruction moves them
    // no multiply term appears here, whatever the product
    always_comb begin
        // hold by default
        nxt_flags = flags_ff;
        if (flags_we_in) begin
            nxt_flags = flags_data_in;
        end
    end

    // register the flags
    // reset clears them with the other registers
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            flags_ff <= FLAG_INIT;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // completion pulse: high for one cycle after each multiply
    // back to back multiplies keep it high
    always_comb begin
        nxt_done = mul_go_in;
    end

    // register the completion pulse
    // reset clears it with the other registers
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= nxt_done;
        end
    end

    // outputs come straight from the registers
    assign working_register_out  = working_register_ff;
    assign product_high_byte_out = prod_hi_ff;
    assign product_low_byte_out  = prod_lo_ff;
    assign alu_flag_register_out = flags_ff;
    assign mul_done_out          = done_ff;
endmodule
